//--- rtl/hspm_defines.svh
`ifndef HSPM_DEFINES_SVH
`define HSPM_DEFINES_SVH

// configuration byte addresses
`define HSPM_OFS_POWER_STATE     8'hE0
`define HSPM_OFS_POWER_STATE_HI  8'hE1
`define HSPM_OFS_BRIDGE_SUPPORT  8'hE2
`define HSPM_OFS_POWER_DATA      8'hE3
`define HSPM_OFS_CAP_TAG         8'hE4
`define HSPM_OFS_NEXT_ITEM       8'hE5
`define HSPM_OFS_SWAP_CTRL       8'hE6

// bridge support byte fields
`define HSPM_BIT_BUS_PWR_EN      7
`define HSPM_BIT_B2B3_STOP       6

// swap control/status byte fields
`define HSPM_BIT_INSERTED        7
`define HSPM_BIT_EXTRACTING      6
`define HSPM_BIT_LAMP            3
`define HSPM_BIT_ENUM_MASK       1

// read values and reset values
`define HSPM_CAP_TAG_NATIVE      8'h06
`define HSPM_CAP_TAG_COMPAT      8'h00
`define HSPM_NEXT_ITEM_VALUE     8'h00
`define HSPM_POWER_DATA_VALUE    8'h00
`define HSPM_UNMAPPED_VALUE      8'h00
`define HSPM_SWAP_CTRL_RESET     8'h00

// power state encodings
`define HSPM_PSTATE_D0           2'h0
`define HSPM_PSTATE_D1           2'h1
`define HSPM_PSTATE_D2           2'h2
`define HSPM_PSTATE_D3HOT        2'h3

// secondary clock enable divider, primary cycles per tick
`define HSPM_SEC_DIV_DEFAULT     8'h02

`endif

//--- rtl/hspm_pkg.sv
package hspm_pkg;

  typedef struct packed {
    logic [7:0] rd_data;
    logic [1:0] power_state;
    logic       inserted;
    logic       extracting;
    logic       lamp_ctrl;
    logic       enum_mask;
    logic       lamp_hold;
    logic       insert_armed;
    logic       handle_closed_d;
    logic       enum_pin;
    logic       lamp_pin;
    logic [7:0] div_cnt;
    logic       sec_tick;
    logic       sec_run;
  } hspm_state_t;

endpackage : hspm_pkg

//--- rtl/hspm_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "hspm_defines.svh"

module hspm_regs #(
  parameter logic [7:0] SEC_DIV = `HSPM_SEC_DIV_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic       bus_clock_control_strap,
  input  wire logic       native_mode,
  input  wire logic       preload_done,
  input  wire logic       handle_closed,
  output logic      [7:0] rd_data,
  output logic      [1:0] power_state,
  output logic            enumeration_request_pin,
  output logic            swap_indicator_lamp,
  output logic            sec_clk_tick,
  output logic            sec_clk_running
);

  hspm_pkg::hspm_state_t s;
  hspm_pkg::hspm_state_t next_s;

  logic       wr_swap;
  logic       wr_power;
  logic       handle_opened;
  logic       insert_set;
  logic       extract_set;
  logic       insert_clr;
  logic       extract_clr;
  logic       stop_in_d3;
  logic [7:0] support_byte;
  logic [7:0] swap_byte;

  assign wr_swap  = wr_en && (addr == `HSPM_OFS_SWAP_CTRL);
  assign wr_power = wr_en && (addr == `HSPM_OFS_POWER_STATE);

  // handle edge is taken from the previous closed level; the input is synchronous
  assign handle_opened = s.handle_closed_d && !handle_closed;

  // one insertion report per arming; re-armed by an extraction so a reseat reports again
  assign insert_set  = s.insert_armed && preload_done && handle_closed
                       && !s.extracting;
  assign extract_set = handle_opened && !s.inserted;

  // software may only clear the status bits, by writing 1
  assign insert_clr  = wr_swap && wr_data[`HSPM_BIT_INSERTED];
  assign extract_clr = wr_swap && wr_data[`HSPM_BIT_EXTRACTING];

  assign stop_in_d3 = bus_clock_control_strap;

  always_comb begin
    support_byte = 8'h00;
    support_byte[`HSPM_BIT_BUS_PWR_EN] = bus_clock_control_strap;
    support_byte[`HSPM_BIT_B2B3_STOP]  = bus_clock_control_strap;
  end

  always_comb begin
    swap_byte = 8'h00;
    swap_byte[`HSPM_BIT_INSERTED]   = s.inserted;
    swap_byte[`HSPM_BIT_EXTRACTING] = s.extracting;
    swap_byte[`HSPM_BIT_LAMP]       = s.lamp_ctrl;
    swap_byte[`HSPM_BIT_ENUM_MASK]  = s.enum_mask;
  end

  always_comb begin
    next_s = s;
    next_s.sec_tick = 1'b0;

    // read data stands only in the cycle after the strobe
    next_s.rd_data = `HSPM_UNMAPPED_VALUE;
    if (rd_en) begin
      unique case (addr)
        `HSPM_OFS_POWER_STATE:    next_s.rd_data = {6'h00, s.power_state};
        `HSPM_OFS_BRIDGE_SUPPORT: next_s.rd_data = support_byte;
        `HSPM_OFS_POWER_DATA:     next_s.rd_data = `HSPM_POWER_DATA_VALUE;
        `HSPM_OFS_CAP_TAG: begin
          next_s.rd_data = native_mode ? `HSPM_CAP_TAG_NATIVE
                                       : `HSPM_CAP_TAG_COMPAT;
        end
        `HSPM_OFS_NEXT_ITEM:      next_s.rd_data = `HSPM_NEXT_ITEM_VALUE;
        `HSPM_OFS_SWAP_CTRL:      next_s.rd_data = swap_byte;
        default:                  next_s.rd_data = `HSPM_UNMAPPED_VALUE;
      endcase
    end

    // only the two writable bits of each byte are stored; other bits are dropped, except swap bits 7 and 6, which clear status
    if (wr_power) begin
      next_s.power_state = wr_data[1:0];
    end
    if (wr_swap) begin
      next_s.lamp_ctrl = wr_data[`HSPM_BIT_LAMP];
      next_s.enum_mask = wr_data[`HSPM_BIT_ENUM_MASK];
    end

    // a set in the same cycle as a clear wins; the mask plays no part here
    next_s.inserted   = insert_set  || (s.inserted   && !insert_clr);
    next_s.extracting = extract_set || (s.extracting && !extract_clr);

    if (insert_set) begin
      next_s.insert_armed = 1'b0;
    end else if (extract_set) begin
      next_s.insert_armed = 1'b1;
    end

    next_s.handle_closed_d = handle_closed;

    // indicator is forced on from reset until the handle first closes
    if (handle_closed) begin
      next_s.lamp_hold = 1'b0;
    end
    next_s.lamp_pin = next_s.lamp_hold ? 1'b1 : next_s.lamp_ctrl;

    next_s.enum_pin = (next_s.inserted || next_s.extracting)
                      && !next_s.enum_mask;

    // secondary clock enable: divided from clk, so it halts whenever clk halts
    next_s.sec_run = !(stop_in_d3 && (next_s.power_state == `HSPM_PSTATE_D3HOT));
    if (!s.sec_run) begin
      next_s.div_cnt = 8'h00;
    end else if (s.div_cnt >= SEC_DIV - 8'h01) begin
      next_s.div_cnt  = 8'h00;
      next_s.sec_tick = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s              <= '0;
      s.lamp_hold    <= 1'b1;
      s.lamp_pin     <= 1'b1;
      s.insert_armed <= 1'b1;
      s.sec_run      <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data                 = s.rd_data;
  assign power_state             = s.power_state;
  assign enumeration_request_pin = s.enum_pin;
  assign swap_indicator_lamp     = s.lamp_pin;
  assign sec_clk_tick            = s.sec_tick;
  assign sec_clk_running         = s.sec_run;

endmodule : hspm_regs

`default_nettype wire

//--- tb/hspm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hspm_chk (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic       bus_clock_control_strap,
  input wire logic       native_mode,
  input wire logic [7:0] rd_data,
  input wire logic [1:0] power_state,
  input wire logic       enumeration_request_pin,
  input wire logic       sec_clk_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_rd_idle: assert property (!$past(rd_en) |-> rd_data == 8'h00)
    else $error("read data outside slot");
  chk_support_mirror: assert property (rd_en && addr == 8'hE2 |=>
    rd_data == {{2{$past(bus_clock_control_strap)}}, 6'h00}) else $error("support byte");
  chk_data_zero: assert property (rd_en && addr == 8'hE3 |=> rd_data == 8'h00)
    else $error("data byte");
  chk_tag_mode: assert property (rd_en && addr == 8'hE4 |=>
    rd_data == ($past(native_mode) ? 8'h06 : 8'h00)) else $error("tag byte");
  chk_next_zero: assert property (rd_en && addr == 8'hE5 |=> rd_data == 8'h00)
    else $error("next pointer");
  chk_resv_zero: assert property (rd_en && addr == 8'hE6 |=> (rd_data & 8'h35) == 8'h00)
    else $error("reserved bits");
  chk_pstate_wr: assert property (wr_en && addr == 8'hE0 |=>
    {6'h00, power_state} == ($past(wr_data) & 8'h03)) else $error("power state");
  chk_clk_stop: assert property (!sec_clk_running |-> power_state == 2'h3)
    else $error("clock stop outside D3hot");
  cover property (rd_en && addr == 8'hE6);
  cover property (enumeration_request_pin);
  cover property (!sec_clk_running);
endmodule : hspm_chk
`default_nettype wire

//--- tb/hspm_host.sv
`timescale 1ns/1ps
`default_nettype none
module hspm_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output var  logic [7:0] addr,
  output var  logic [7:0] wr_data,
  output var  logic       wr_en,
  output var  logic       rd_en
);
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // returns 1 ns after the taking edge so outputs have settled
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd
endmodule : hspm_host
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk = 1'b0, reset_n = 1'b0, strap = 1'b0, native = 1'b1, pd = 1'b0, hc = 1'b0;
  logic [7:0] addr, wd, rdv, rd_data;
  logic       wr_en, rd_en, en_pin, lamp, tick, run;
  logic [1:0] ps;
  int         bad_count = 0, n_checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  hspm_host hspm_host_inst (.clk(clk), .rd_data(rd_data), .addr(addr), .wr_data(wd),
    .wr_en(wr_en), .rd_en(rd_en));
  hspm_regs #(.SEC_DIV(8'h02)) hspm_regs_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wr_data(wd), .wr_en(wr_en), .rd_en(rd_en), .bus_clock_control_strap(strap),
    .native_mode(native), .preload_done(pd), .handle_closed(hc), .rd_data(rd_data),
    .power_state(ps), .enumeration_request_pin(en_pin), .swap_indicator_lamp(lamp),
    .sec_clk_tick(tick), .sec_clk_running(run));
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [7:0] e);
    hspm_host_inst.rd(a, rdv);
    chk(rdv, e);
  endtask : rc
  task t_swap;
    chk(8'(lamp), 8'h01);
    rc(8'hE6, 8'h00);
    hspm_host_inst.wr(8'hE6, 8'hC0);
    rc(8'hE6, 8'h00);
    chk(8'(lamp), 8'h01);
    @(posedge clk) pd <= 1'b1;
    hc <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(8'(en_pin), 8'h01);
    chk(8'(lamp), 8'h00);
    rc(8'hE6, 8'h80);
    hspm_host_inst.wr(8'hE6, 8'h0A);
    @(posedge clk) #1 chk(8'(en_pin), 8'h00);
    chk(8'(lamp), 8'h01);
    rc(8'hE6, 8'h8A);
    hspm_host_inst.wr(8'hE6, 8'h82);
    @(posedge clk) #1 chk(8'(lamp), 8'h00);
    @(posedge clk) hc <= 1'b0;
    repeat (3) @(posedge clk);
    rc(8'hE6, 8'h42);
    hspm_host_inst.wr(8'hE6, 8'h00);
    @(posedge clk) #1 chk(8'(en_pin), 8'h01);
    $display("t_swap done");
  endtask : t_swap
  task t_ids;
    rc(8'hE2, 8'h00);
    @(posedge clk) strap <= 1'b1;
    rc(8'hE2, 8'hC0);
    for (int i = 3; i < 6; i++) hspm_host_inst.wr(8'(8'hE0 + i), 8'hFF);
    rc(8'hE3, 8'h00);
    rc(8'hE4, 8'h06);
    rc(8'hE5, 8'h00);
    @(posedge clk) native <= 1'b0;
    rc(8'hE4, 8'h00);
    rc(8'hF0, 8'h00);
    $display("t_ids done");
  endtask : t_ids
  task t_pwr;
    int n;
    for (int p = 0; p < 4; p++) begin
      hspm_host_inst.wr(8'hE0, 8'(p));
      @(posedge clk) #1 chk(8'(ps), 8'(p));
      chk(8'(run), 8'(p != 3));
      n = 0;
      repeat (4) @(posedge clk) #1 n += int'(tick);
      chk(8'(n), (p == 3) ? 8'h00 : 8'h02);
      rc(8'hE0, 8'(p));
    end
    @(posedge clk) strap <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(8'(run), 8'h01);
    hspm_host_inst.wr(8'hE0, 8'h00);
    $display("t_pwr done");
  endtask : t_pwr
  task t_reset;
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(8'(en_pin), 8'h00);
    chk(8'(lamp), 8'h01);
    @(posedge clk) reset_n <= 1'b1;
    pd <= 1'b0;
    rc(8'hE6, 8'h00);
    rc(8'hE0, 8'h00);
    @(posedge clk) hc <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(8'(en_pin), 8'h00);
    chk(8'(lamp), 8'h00);
    @(posedge clk) pd <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk(8'(en_pin), 8'h01);
    $display("t_reset done");
  endtask : t_reset
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // the whole run is about 120 cycles, so the ceiling is generous
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_swap;
    t_ids;
    t_pwr;
    t_reset;
    final_report;
  end
endmodule : tb_top
bind hspm_regs hspm_chk hspm_chk_inst (.clk(clk), .reset_n(reset_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
  .bus_clock_control_strap(bus_clock_control_strap), .native_mode(native_mode),
  .rd_data(rd_data), .power_state(power_state),
  .enumeration_request_pin(enumeration_request_pin), .sec_clk_running(sec_clk_running));
`default_nettype wire
